/* rtl/ssd_pkg.sv */
// shared constants and types for the stage switch selector decoder
package ssd_pkg;
  localparam int SSD_ADDR_W = 2;
  localparam int SSD_DATA_W = 16;
  localparam int SSD_CODE_W = 8;
  localparam int SSD_KEY_W = 5;
  localparam int SSD_OUT_N = 128;
  localparam int SSD_IDX_W = 7;

  // register offsets
  localparam logic [SSD_ADDR_W-1:0] SSD_ADDR_CMD = 2'h0;
  localparam logic [SSD_ADDR_W-1:0] SSD_ADDR_STATUS = 2'h1;

  // field positions within the command word
  localparam int SSD_POS_CODE = 0;
  localparam int SSD_POS_KEY = 8;
  localparam int SSD_POS_RESET = 13;
  localparam int SSD_POS_READ = 14;

  // reset values
  localparam logic [SSD_CODE_W-1:0] SSD_CODE_RST = 8'h00;
  localparam logic [SSD_KEY_W-1:0] SSD_KEY_RST = 5'h00;
  localparam logic [SSD_DATA_W-1:0] SSD_RDATA_RST = 16'h0000;

  // output driver pulse length
  localparam int SSD_CLK_PERIOD_PS = 25000;
  localparam int SSD_FIRE_TIME_NS = 1000;
  localparam int SSD_FIRE_CYCLES =
    (SSD_FIRE_TIME_NS * 1000 + SSD_CLK_PERIOD_PS - 1) / SSD_CLK_PERIOD_PS;
  localparam int SSD_CNT_W = 12;

  typedef struct packed {
    logic read;
    logic reset;
    logic [SSD_KEY_W-1:0] key;
    logic [SSD_CODE_W-1:0] code;
  } ssd_cmd_t;

  typedef enum logic [1:0] {
    SSD_IDLE = 2'b00,
    SSD_LOADED = 2'b01,
    SSD_FIRE = 2'b10
  } ssd_state_t;
endpackage

/* rtl/ssd_decoder.sv */
// stage switch selector: command latch, verification feedback, driver decode
// Contract
// RULE_01 - word bits 1..8 hold the function code selecting the stage output
// RULE_02 - bits 9..13 hold stage key; only a matching selector is addressed
// RULE_03 - bit 14 set resets every relay, dropping the command, no output
// RULE_04 - bit 15 set makes the addressed selector fire the latched command
// RULE_05 - controller loads in two passes: bits 1..13, then reset or read
// RULE_06 - after latching, complement of received code returns on 8 lines
// RULE_07 - controller compares feedback and issues read when it agrees
// RULE_08 - on mismatch controller forces reset, resends code complemented; the host model only issues the reset and never resends
// RULE_09 - true and complemented code drive the very same output
// RULE_10 - each code maps to exactly one driver, only that one fires on read
// RULE_11 - positive logic: high is binary one, low is binary zero
// RULE_12 - key mismatch ignores read and reset; after reset a new pass 1 fits
`timescale 1ns/1ps
module ssd_decoder
  import ssd_pkg::*;
#(
  parameter logic [ssd_pkg::SSD_KEY_W-1:0] STAGE_KEY = 5'h01,
  parameter int FIRE_CYCLES = ssd_pkg::SSD_FIRE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ssd_pkg::SSD_ADDR_W-1:0] reg_addr,
  input wire logic [ssd_pkg::SSD_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [ssd_pkg::SSD_DATA_W-1:0] reg_rdata,
  output logic [ssd_pkg::SSD_CODE_W-1:0] verify_code,
  output logic [ssd_pkg::SSD_OUT_N-1:0] stage_drive,
  output logic cmd_loaded,
  output logic cmd_firing
);
  import ssd_pkg::*;

  localparam logic [SSD_CNT_W-1:0] FIRE_LAST =
    SSD_CNT_W'(FIRE_CYCLES - 1);

  ssd_state_t state;
  ssd_state_t next_state;
  logic [SSD_CODE_W-1:0] code;
  logic [SSD_CODE_W-1:0] next_code;
  logic [SSD_CNT_W-1:0] fire_cnt;
  logic [SSD_CNT_W-1:0] next_fire_cnt;
  logic [SSD_CODE_W-1:0] next_verify_code;
  logic [SSD_OUT_N-1:0] next_stage_drive;
  logic [SSD_DATA_W-1:0] next_reg_rdata;

  // decode of the bus word
  ssd_cmd_t wcmd;
  wire cmd_sel = reg_addr == SSD_ADDR_CMD;
  wire stat_sel = reg_addr == SSD_ADDR_STATUS;
  wire cmd_wr = reg_write && cmd_sel;
  assign wcmd = ssd_cmd_t'(reg_wdata[SSD_POS_READ:SSD_POS_CODE]);

  wire key_match = wcmd.key == STAGE_KEY; // RULE_02
  // pass 1 carries neither control bit; pass 2 only one of them
  wire is_pass1 = cmd_wr && !wcmd.reset && !wcmd.read; // RULE_05
  wire take_pass1 = is_pass1 && key_match; // RULE_02
  // pass 2 carries no key, so addressing rests on the pass 1 latch
  wire addressed = state != SSD_IDLE; // RULE_12
  wire do_reset = cmd_wr && wcmd.reset && addressed; // RULE_03
  wire do_read = cmd_wr && wcmd.read && !wcmd.reset &&
    state == SSD_LOADED; // RULE_04
  wire fire_done = state == SSD_FIRE && fire_cnt == FIRE_LAST;

  // fold complemented form onto the true form
  wire [SSD_IDX_W-1:0] drive_idx = code[SSD_CODE_W-1] ?
    ~code[SSD_IDX_W-1:0] : code[SSD_IDX_W-1:0]; // RULE_09
  wire [SSD_OUT_N-1:0] drive_onehot =
    SSD_OUT_N'(1) << drive_idx; // RULE_10

  // status word: state flags and feedback
  wire [SSD_DATA_W-1:0] status_word = {
    6'h00, (state == SSD_FIRE), (state == SSD_LOADED), verify_code};
  wire [SSD_DATA_W-1:0] cmd_word = {
    8'h00, code};

  always_comb begin
    next_state = state;
    next_code = code;
    next_fire_cnt = fire_cnt;
    unique case (state)
      SSD_IDLE: begin
        if (take_pass1) begin
          next_state = SSD_LOADED;
          next_code = wcmd.code; // RULE_01
        end
      end
      SSD_LOADED: begin
        if (do_reset) begin
          next_state = SSD_IDLE; // RULE_03
          next_code = SSD_CODE_RST;
        end else if (do_read) begin
          next_state = SSD_FIRE; // RULE_04
          next_fire_cnt = '0;
        end else if (take_pass1) begin
          next_code = wcmd.code; // RULE_12
        end
      end
      SSD_FIRE: begin
        if (do_reset || fire_done) begin
          next_state = SSD_IDLE; // RULE_03
          next_code = SSD_CODE_RST;
          next_fire_cnt = '0;
        end else begin
          next_fire_cnt = fire_cnt + SSD_CNT_W'(1);
        end
      end
      default: begin
        next_state = SSD_IDLE;
        next_code = SSD_CODE_RST;
        next_fire_cnt = '0;
      end
    endcase
  end

  // feedback follows the latch; drivers follow the firing state
  assign next_verify_code = (next_state == SSD_IDLE) ?
    SSD_CODE_RST : ~next_code; // RULE_06
  assign next_stage_drive = (next_state == SSD_FIRE) ?
    drive_onehot_next() : '0; // RULE_10

  function automatic logic [SSD_OUT_N-1:0] drive_onehot_next();
    logic [SSD_IDX_W-1:0] idx;
    idx = next_code[SSD_CODE_W-1] ?
      ~next_code[SSD_IDX_W-1:0] : next_code[SSD_IDX_W-1:0]; // RULE_09
    return SSD_OUT_N'(1) << idx;
  endfunction

  // read data valid only in the cycle after the strobe
  assign next_reg_rdata = !reg_read ? SSD_RDATA_RST :
    stat_sel ? status_word :
    cmd_sel ? cmd_word : SSD_RDATA_RST;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SSD_IDLE;
      code <= SSD_CODE_RST;
      fire_cnt <= '0;
    end else begin
      state <= next_state;
      code <= next_code;
      fire_cnt <= next_fire_cnt;
    end
  end

  // all ports straight from flops, positive logic throughout
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      verify_code <= SSD_CODE_RST;
      stage_drive <= '0;
      cmd_loaded <= 1'b0;
      cmd_firing <= 1'b0;
      reg_rdata <= SSD_RDATA_RST;
    end else begin
      verify_code <= next_verify_code; // RULE_11
      stage_drive <= next_stage_drive; // RULE_11
      cmd_loaded <= next_state == SSD_LOADED;
      cmd_firing <= next_state == SSD_FIRE;
      reg_rdata <= next_reg_rdata;
    end
  end

  // drive_onehot is only folded into unused_onehot; the status word does not carry it
  wire unused_onehot = ^drive_onehot;
endmodule

/* verif/ssd_sva.sv */
// port assertions for the stage selector decoder
`timescale 1ns/1ps
module ssd_sva
  import ssd_pkg::*;
#(
  parameter logic [ssd_pkg::SSD_KEY_W-1:0] STAGE_KEY = 5'h01,
  parameter int FIRE_CYCLES = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ssd_pkg::SSD_ADDR_W-1:0] reg_addr,
  input wire logic [ssd_pkg::SSD_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [ssd_pkg::SSD_CODE_W-1:0] verify_code,
  input wire logic [ssd_pkg::SSD_OUT_N-1:0] stage_drive,
  input wire logic cmd_loaded,
  input wire logic cmd_firing
);
  wire logic cw = reg_write && reg_addr == SSD_ADDR_CMD;
  wire logic idle = !cmd_loaded && !cmd_firing;
  wire logic [1:0] op = reg_wdata[14:13];
  wire logic key_ok = reg_wdata[12:8] == STAGE_KEY;
  // echo is the complement, so undo it before picking the driver
  wire logic [6:0] idx = verify_code[7] ? ~verify_code[6:0] : verify_code[6:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_load; cw && op == 2'h0 && key_ok && !cmd_firing |=>
    cmd_loaded && verify_code == ~$past(reg_wdata[7:0]); endproperty
  a_load: assert property (p_load) else $error("echo wrong");
  property p_key; cw && op == 2'h0 && !key_ok && idle |=> idle; endproperty
  a_key: assert property (p_key) else $error("foreign key taken");
  property p_rst; cw && reg_wdata[13] |=> idle; endproperty
  a_rst: assert property (p_rst) else $error("reset ignored");
  property p_read; cw && op == 2'h2 && cmd_loaded |=> cmd_firing; endproperty
  a_read: assert property (p_read) else $error("read ignored");
  // pulse length fixed for the 3 cycle build used in simulation
  property p_len; $rose(cmd_firing) |-> cmd_firing [*3] ##1 !cmd_firing;
  endproperty
  a_len: assert property (p_len) else $error("pulse length");
  property p_map; stage_drive == (cmd_firing ? 128'h1 << idx : 128'h0);
  endproperty
  a_map: assert property (p_map) else $error("driver select");
  property p_idle; idle |-> verify_code == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stale echo");
  property p_unmap; reg_write && reg_addr != SSD_ADDR_CMD && idle |=> idle;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped write");
endmodule
bind ssd_decoder ssd_sva #(.STAGE_KEY(STAGE_KEY), .FIRE_CYCLES(FIRE_CYCLES))
  sva(.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .verify_code(verify_code),
  .stage_drive(stage_drive), .cmd_loaded(cmd_loaded),
  .cmd_firing(cmd_firing));

/* verif/ssd_host.sv */
// guidance side model: builds pass one from the sent code, pass two from the echo
`timescale 1ns/1ps
module ssd_host
  import ssd_pkg::*;
#(parameter logic [ssd_pkg::SSD_KEY_W-1:0] KEY = 5'h01) (
  input wire logic [ssd_pkg::SSD_CODE_W-1:0] sent,
  input wire logic [ssd_pkg::SSD_CODE_W-1:0] verify_code,
  output logic [ssd_pkg::SSD_DATA_W-1:0] pass1,
  output logic [ssd_pkg::SSD_DATA_W-1:0] pass2
);
  assign pass1 = {3'b000, KEY, sent};
  // only one of reset or read in pass two, never both
  assign pass2 = verify_code == ~sent ? 16'h4000 : 16'h2000;
endmodule

/* verif/tb.sv */
// self-checking bench for the stage selector decoder
`timescale 1ns/1ps
module tb;
  import ssd_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, pass1, pass2;
  logic [7:0] verify_code, sent = 8'h00;
  logic [127:0] stage_drive;
  logic cmd_loaded, cmd_firing;
  int err_total = 0, checks_done = 0, cyc = 0;
  ssd_decoder #(.FIRE_CYCLES(3)) dut(.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .verify_code(verify_code),
    .stage_drive(stage_drive), .cmd_loaded(cmd_loaded),
    .cmd_firing(cmd_firing));
  ssd_host host(.sent(sent), .verify_code(verify_code), .pass1(pass1),
    .pass2(pass2));
  task automatic chk(input string n, input logic [127:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
  endtask
  task automatic t_fire(input logic [7:0] c, input int idx);
    sent = c;
    #1;
    wr(2'h0, pass1);
    chk("echo", verify_code, {~c});
    rd(2'h1);
    chk("status", reg_rdata, {8'h01, ~c});
    rd(2'h0);
    chk("cmd word", reg_rdata, {8'h00, c});
    wr(2'h0, pass2);
    chk("drive", stage_drive, 128'h1 << idx);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("drop", {cmd_firing, verify_code}, 128'h0);
    $display("fire test done");
  endtask
  task automatic t_refuse;
    wr(2'h0, 16'h0235);
    chk("key miss", cmd_loaded, 128'h0);
    wr(2'h2, 16'h0135);
    chk("unmapped", cmd_loaded, 128'h0);
    wr(2'h0, 16'h4000);
    chk("idle read", stage_drive, 128'h0);
    sent = 8'h00;
    wr(2'h0, 16'h0135);
    wr(2'h0, pass2);
    chk("reset", {cmd_loaded, cmd_firing, stage_drive}, 128'h0);
    $display("refuse test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // far above the roughly forty cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_refuse;
    t_fire(8'h35, 53);
    t_fire(8'hca, 53);
    print_verdict;
  end
endmodule
